// ===== core/dres_pkg.sv
// Constants and types shared by the drive and error status register block.
package dres_pkg;

	// Register field positions.
	localparam int DRES_ODS_MSB = 7;
	localparam int DRES_ODS_LSB = 5;
	localparam int DRES_RSV4_POS = 4;
	localparam int DRES_RSV3_POS = 3;
	localparam int DRES_PERR_POS = 2;
	localparam int DRES_PROT_POS = 1;
	localparam int DRES_BUSY_POS = 0;

	// Values after reset.
	localparam logic [2:0] DRES_ODS_RST = 3'h7;
	localparam logic DRES_RSV4_VAL = 1'h1;
	localparam logic DRES_RSV3_VAL = 1'h0;
	localparam logic DRES_FLAG_RST = 1'h0;
	localparam logic DRES_BUSY_RST = 1'h0;
	localparam logic [3:0] DRES_EIGHTHS_RST = 4'h4;

	// Drive strength codes.
	localparam logic [2:0] DRES_ODS_RSV0 = 3'h0;
	localparam logic [2:0] DRES_ODS_12P5 = 3'h1;
	localparam logic [2:0] DRES_ODS_25 = 3'h2;
	localparam logic [2:0] DRES_ODS_37P5 = 3'h3;
	localparam logic [2:0] DRES_ODS_RSV4 = 3'h4;
	localparam logic [2:0] DRES_ODS_75 = 3'h5;
	localparam logic [2:0] DRES_ODS_100 = 3'h6;
	localparam logic [2:0] DRES_ODS_50 = 3'h7;

	// Serial opcodes.
	localparam logic [7:0] DRES_OPC_SET_NV = 8'h85;
	localparam logic [7:0] DRES_OPC_SET_V = 8'h83;
	localparam logic [7:0] DRES_OPC_CLR = 8'h82;
	localparam logic [7:0] DRES_OPC_RD = 8'h81;

	// Serial bit counts.
	localparam logic [4:0] DRES_OPC_LAST = 5'h07;
	localparam logic [4:0] DRES_DATA_LAST = 5'h0f;
	localparam logic [4:0] DRES_CNT_SAT = 5'h1f;
	localparam logic [4:0] DRES_RD_WRAP = 5'h18;

	// Kind of internal operation that has just terminated.
	typedef enum logic [3:0] {
		DRES_OP_PAGE_PGM,
		DRES_OP_PPB_PGM,
		DRES_OP_PWD_PGM,
		DRES_OP_IR_PGM,
		DRES_OP_ASP_PGM,
		DRES_OP_PWD_UNLOCK,
		DRES_OP_SR_WRITE,
		DRES_OP_NV_REG_WRITE,
		DRES_OP_FR_WRITE,
		DRES_OP_SECT_ERASE,
		DRES_OP_CHIP_ERASE,
		DRES_OP_IR_ERASE,
		DRES_OP_PPB_ERASE,
		DRES_OP_OTHER
	} dres_op_e;

endpackage : dres_pkg

// ===== core/dres_sync.sv
// Two flip-flop synchroniser for levels and toggles.
`timescale 1ns/1ps
module dres_sync
	import dres_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] meta_ff;
		logic [W-1:0] q_ff;
	} dres_sync_s;

	dres_sync_s st_ff;
	dres_sync_s nxt_st;

	always_comb begin
		nxt_st.meta_ff = i_d;
		nxt_st.q_ff = st_ff.meta_ff;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_q = st_ff.q_ff;

endmodule : dres_sync

// ===== core/dres_link.sv
// Serial-clock side: opcode and data capture, register read-out.
`timescale 1ns/1ps
module dres_link
	import dres_pkg::*;
(
	input wire logic i_sck,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	input wire logic [7:0] i_status,
	output logic o_miso,
	output logic o_miso_oe_n,
	output logic o_evt_tog,
	output logic [15:0] o_evt_word
);

	typedef struct packed {
		logic [4:0] cnt_ff;
		logic [7:0] sh_ff;
		logic [7:0] op_ff;
		logic rd_ff;
		logic [7:0] tx_ff;
	} dres_frm_s;

	typedef struct packed {
		logic tog_ff;
		logic [15:0] word_ff;
	} dres_evt_s;

	dres_frm_s frm_ff;
	dres_frm_s nxt_frm;
	dres_evt_s evt_ff;
	dres_evt_s nxt_evt;
	logic [7:0] stat_sync;
	logic [7:0] rx_byte;
	logic frm_rst;

	// Bits 2:0 are independent flags but bits 7:5 form one drive code; each bit is synchronised on its own.
	dres_sync #(.W(8)) u_stat_sync (
		.i_clk(i_sck),
		.i_rst(i_rst),
		.i_d(i_status),
		.o_q(stat_sync)
	);

	assign rx_byte = {frm_ff.sh_ff[6:0], i_mosi};
	// The frame state dies with chip select, as the serial clock stops between frames.
	assign frm_rst = i_rst | i_cs_n;

	always_comb begin
		nxt_frm = frm_ff;
		nxt_evt = evt_ff;
		nxt_frm.sh_ff = rx_byte;
		if (frm_ff.cnt_ff != DRES_CNT_SAT) begin
			nxt_frm.cnt_ff = frm_ff.cnt_ff + 5'h01;
		end else if (frm_ff.rd_ff) begin
			// A long read folds back into the last byte slot so the reload keeps its pace.
			nxt_frm.cnt_ff = DRES_RD_WRAP;
		end
		if (frm_ff.cnt_ff == DRES_OPC_LAST) begin
			nxt_frm.op_ff = rx_byte;
			if (rx_byte == DRES_OPC_RD) begin
				nxt_frm.rd_ff = 1'b1;
				nxt_frm.tx_ff = stat_sync;
			end
			if (rx_byte == DRES_OPC_CLR) begin
				nxt_evt.tog_ff = ~evt_ff.tog_ff;
				nxt_evt.word_ff = {rx_byte, 8'h00};
			end
		end else if (frm_ff.rd_ff) begin
			// Repeated reads return a fresh copy every byte.
			if (frm_ff.cnt_ff[2:0] == DRES_OPC_LAST[2:0]) begin
				nxt_frm.tx_ff = stat_sync;
			end else begin
				nxt_frm.tx_ff = {frm_ff.tx_ff[6:0], 1'b0};
			end
		end
		if (frm_ff.cnt_ff == DRES_DATA_LAST &&
				(frm_ff.op_ff == DRES_OPC_SET_NV || frm_ff.op_ff == DRES_OPC_SET_V)) begin
			nxt_evt.tog_ff = ~evt_ff.tog_ff;
			nxt_evt.word_ff = {frm_ff.op_ff, rx_byte};
		end
	end

	always_ff @(posedge i_sck or posedge frm_rst) begin
		if (frm_rst) begin
			frm_ff <= '0;
		end else begin
			frm_ff <= nxt_frm;
		end
	end

	always_ff @(posedge i_sck or posedge i_rst) begin
		if (i_rst) begin
			evt_ff <= '0;
		end else begin
			evt_ff <= nxt_evt;
		end
	end

	assign o_miso = frm_ff.tx_ff[7];
	assign o_miso_oe_n = ~frm_ff.rd_ff;
	assign o_evt_tog = evt_ff.tog_ff;
	assign o_evt_word = evt_ff.word_ff;

endmodule : dres_link

// ===== core/dres_top.sv
// Drive strength and error status register with its serial access path.
//
// Operation
// - Bits 7:5 drive strength, volatile and persistent.
// - Decode drive codes; 111 is default.
// - Bits 3:0 untouched by set commands.
// - 85h sets persistent copy, 83h volatile.
// - Bit 0 mirrors the busy flag.
// - Bit 1 flags protection faults.
// - Bit 2 flags program or register failures.
// - Program faults set flags; protected also protection.
// - Info row program fault and lock handling.
// - Bad protection config program sets both flags.
// - Password mismatch sets both flags.
// - Register write erase/program failure sets program flag.
// - Locked status write sets protection flag.
// - Erase of protected target sets protection flag.
// - Whole erase checks block protect bits only.
// - One-way bits cleared silently, no error.
// - Read-only data bits discarded without error.
// - Flags stay until clear or reset.
// - Set flags never block later commands.
// - Reset: drive 111, bit4 1, flags 0.
`timescale 1ns/1ps
module dres_top
	import dres_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe_n,
	input wire logic i_wp_n,
	input wire logic i_status_write_disable_bit,
	input wire logic i_write_busy_flag,
	input wire logic i_soft_rst,
	input wire logic i_op_end,
	input wire dres_op_e i_op_kind,
	input wire logic i_op_fail,
	input wire logic i_tgt_protected,
	input wire logic i_tgt_suspended,
	input wire logic i_ir_locked,
	input wire logic i_asp_mode_set,
	input wire logic [1:0] i_asp_cur,
	input wire logic [1:0] i_asp_new,
	input wire logic i_pwd_match,
	input wire logic i_block_protect_any,
	output logic [7:0] o_reg,
	output logic [2:0] o_drive_strength,
	output logic [2:0] o_nv_drive_strength,
	output logic [3:0] o_drive_eighths,
	output logic o_nv_write
);

	typedef struct packed {
		logic [2:0] vol_ods_ff;
		logic [2:0] nv_ods_ff;
		logic p_err_ff;
		logic protection_fault_flag_ff;
		logic busy_ff;
		logic tog_seen_ff;
		logic nv_wr_ff;
		logic [3:0] eighths_ff;
		logic [7:0] reg_ff;
	} dres_core_s;

	dres_core_s st_ff;
	dres_core_s nxt_st;

	logic evt_tog;
	logic [15:0] evt_word;
	logic tog_sync;
	logic wp_n_sync;
	logic evt_new;
	logic [7:0] evt_op;
	logic [2:0] evt_ods;
	logic clr_cmd;
	logic [1:0] set_flags;
	logic sr_locked;

	// Drive strength in units of one eighth of full drive.
	function automatic logic [3:0] ods_eighths(input logic [2:0] code);
		logic [3:0] res;
		res = 4'h4;
		case (code)
			DRES_ODS_12P5: begin
				res = 4'h1;
			end
			DRES_ODS_25: begin
				res = 4'h2;
			end
			DRES_ODS_37P5: begin
				res = 4'h3;
			end
			DRES_ODS_75: begin
				res = 4'h6;
			end
			DRES_ODS_100: begin
				res = 4'h8;
			end
			DRES_ODS_50: begin
				res = 4'h4;
			end
			default: begin
				res = 4'h4;
			end
		endcase
		return res;
	endfunction : ods_eighths

	// Reserved codes are refused, so the pins never see an undefined drive.
	function automatic logic ods_legal(input logic [2:0] code);
		return (code != DRES_ODS_RSV0) && (code != DRES_ODS_RSV4);
	endfunction : ods_legal

	// Returns {program failure, protection fault} for a finished operation.
	function automatic logic [1:0] err_of(
		input dres_op_e kind,
		input logic fail,
		input logic tgt_prot,
		input logic tgt_susp,
		input logic ir_lock,
		input logic asp_set,
		input logic [1:0] asp_cur,
		input logic [1:0] asp_new,
		input logic pwd_ok,
		input logic sr_lock,
		input logic bp_any
	);
		logic perr;
		logic prot;
		logic bad;
		perr = 1'b0;
		prot = 1'b0;
		bad = 1'b0;
		case (kind)
			DRES_OP_PAGE_PGM,
			DRES_OP_PPB_PGM,
			DRES_OP_PWD_PGM: begin
				bad = tgt_prot | tgt_susp;
				perr = fail | bad;
				prot = bad;
			end
			DRES_OP_IR_PGM: begin
				perr = fail | ir_lock;
				prot = ir_lock;
			end
			DRES_OP_ASP_PGM: begin
				bad = (asp_set && (asp_new != asp_cur)) || (asp_new == 2'h0);
				perr = fail | bad;
				prot = bad;
			end
			DRES_OP_PWD_UNLOCK: begin
				bad = ~pwd_ok;
				perr = bad;
				prot = bad;
			end
			DRES_OP_SR_WRITE: begin
				perr = fail;
				prot = sr_lock;
			end
			DRES_OP_NV_REG_WRITE,
			DRES_OP_FR_WRITE: begin
				// one-way bits silent
				// A cleared one-way bit is not a failure, so only a real fault counts.
				perr = fail;
			end
			DRES_OP_SECT_ERASE,
			DRES_OP_IR_ERASE,
			DRES_OP_PPB_ERASE: begin
				prot = tgt_prot | ir_lock;
			end
			DRES_OP_CHIP_ERASE: begin
				prot = bp_any;
			end
			default: begin
				perr = 1'b0;
				prot = 1'b0;
			end
		endcase
		return {perr, prot};
	endfunction : err_of

	dres_link u_link (
		.i_sck(i_sck),
		.i_rst(i_rst),
		.i_cs_n(i_cs_n),
		.i_mosi(i_mosi),
		.i_status(st_ff.reg_ff),
		.o_miso(o_miso),
		.o_miso_oe_n(o_miso_oe_n),
		.o_evt_tog(evt_tog),
		.o_evt_word(evt_word)
	);

	dres_sync #(.W(2)) u_ref_sync (
		.i_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_d({evt_tog, i_wp_n}),
		.o_q({tog_sync, wp_n_sync})
	);

	// The command word is held in the link until the next set or clear command is captured, which
	// is far longer than the toggle takes to cross, so it is stable here.
	assign evt_new = tog_sync != st_ff.tog_seen_ff;
	assign evt_op = evt_word[15:8];
	assign evt_ods = evt_word[DRES_ODS_MSB:DRES_ODS_LSB];
	assign clr_cmd = evt_new && (evt_op == DRES_OPC_CLR);
	assign sr_locked = i_status_write_disable_bit & ~wp_n_sync;

	always_comb begin
		set_flags = 2'h0;
		if (i_op_end) begin
			set_flags = err_of(
				i_op_kind,
				i_op_fail,
				i_tgt_protected,
				i_tgt_suspended,
				i_ir_locked,
				i_asp_mode_set,
				i_asp_cur,
				i_asp_new,
				i_pwd_match,
				sr_locked,
				i_block_protect_any
			);
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tog_seen_ff = tog_sync;
		nxt_st.nv_wr_ff = 1'b0;
		nxt_st.busy_ff = i_write_busy_flag;
		if (i_soft_rst) begin
			nxt_st.vol_ods_ff = st_ff.nv_ods_ff;
		end else if (evt_new && ods_legal(evt_ods)) begin
			if (evt_op == DRES_OPC_SET_V) begin
				nxt_st.vol_ods_ff = evt_ods;
			end
			if (evt_op == DRES_OPC_SET_NV) begin
				nxt_st.nv_ods_ff = evt_ods;
				nxt_st.vol_ods_ff = evt_ods;
				nxt_st.nv_wr_ff = 1'b1;
			end
		end
		if (clr_cmd || i_soft_rst) begin
			nxt_st.p_err_ff = DRES_FLAG_RST;
			nxt_st.protection_fault_flag_ff = DRES_FLAG_RST;
		end
		// flags set at operation end
		// A fault arriving with a clear wins, so no error is ever lost.
		if (set_flags[1]) begin
			nxt_st.p_err_ff = 1'b1;
		end
		if (set_flags[0]) begin
			nxt_st.protection_fault_flag_ff = 1'b1;
		end
		nxt_st.eighths_ff = ods_eighths(nxt_st.vol_ods_ff);
		nxt_st.reg_ff = {
			nxt_st.vol_ods_ff,
			DRES_RSV4_VAL,
			DRES_RSV3_VAL,
			nxt_st.p_err_ff,
			nxt_st.protection_fault_flag_ff,
			nxt_st.busy_ff
		};
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff.vol_ods_ff <= DRES_ODS_RST;
			st_ff.nv_ods_ff <= DRES_ODS_RST;
			st_ff.p_err_ff <= DRES_FLAG_RST;
			st_ff.protection_fault_flag_ff <= DRES_FLAG_RST;
			st_ff.busy_ff <= DRES_BUSY_RST;
			st_ff.tog_seen_ff <= 1'b0;
			st_ff.nv_wr_ff <= 1'b0;
			st_ff.eighths_ff <= DRES_EIGHTHS_RST;
			st_ff.reg_ff <= {
				DRES_ODS_RST,
				DRES_RSV4_VAL,
				DRES_RSV3_VAL,
				DRES_FLAG_RST,
				DRES_FLAG_RST,
				DRES_BUSY_RST
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// flags never gate commands
	// No path above reads the error flags, so a set flag cannot stall anything.
	assign o_reg = st_ff.reg_ff;
	assign o_drive_strength = st_ff.vol_ods_ff;
	assign o_nv_drive_strength = st_ff.nv_ods_ff;
	assign o_drive_eighths = st_ff.eighths_ff;
	assign o_nv_write = st_ff.nv_wr_ff;

endmodule : dres_top

// ===== testbench/dres_top_sva.sv
// Checker for the drive and error status register block.
`timescale 1ns/1ps
module dres_top_sva
	import dres_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_write_busy_flag,
	input wire logic i_soft_rst,
	input wire logic i_op_end,
	input wire dres_op_e i_op_kind,
	input wire logic [1:0] i_asp_new,
	input wire logic i_tgt_protected,
	input wire logic i_pwd_match,
	input wire logic i_block_protect_any,
	input wire logic [7:0] o_reg,
	input wire logic [2:0] o_drive_strength,
	input wire logic [2:0] o_nv_drive_strength,
	input wire logic [3:0] o_drive_eighths,
	input wire logic o_nv_write
);
	localparam logic [3:0] E8 [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	busy_mirror_a: assert property (o_reg[0] == $past(i_write_busy_flag))
		else $error("busy bit does not follow");
	rsv_bits_a: assert property (o_reg[4:3] == 2'h2)
		else $error("reserved bits wrong");
	drive_view_a: assert property (o_reg[7:5] == o_drive_strength)
		else $error("drive field mismatch");
	drive_decode_a: assert property (o_drive_eighths == E8[o_drive_strength])
		else $error("drive decode wrong");
	no_rsv_code_a: assert property (o_drive_strength[1:0] != 2'h0)
		else $error("reserved drive code taken");
	nv_copy_a: assert property (o_nv_write |-> o_nv_drive_strength == o_drive_strength)
		else $error("copies differ on write");
	prot_pgm_a: assert property (i_op_end && i_op_kind == DRES_OP_PAGE_PGM &&
		i_tgt_protected |=> o_reg[2:1] == 2'h3) else $error("protected program flags");
	pwd_bad_a: assert property (i_op_end && i_op_kind == DRES_OP_PWD_UNLOCK &&
		!i_pwd_match |=> o_reg[2:1] == 2'h3) else $error("password flags");
	asp_zero_a: assert property (i_op_end && i_op_kind == DRES_OP_ASP_PGM &&
		i_asp_new == 2'h0 |=> o_reg[2:1] == 2'h3) else $error("config flags");
	chip_bp_a: assert property (i_op_end && i_op_kind == DRES_OP_CHIP_ERASE &&
		i_block_protect_any |=> o_reg[1]) else $error("whole erase flag");
	soft_clr_a: assert property (i_soft_rst && !i_op_end |=> o_reg[2:1] == 2'h0)
		else $error("soft reset kept flags");
endmodule : dres_top_sva

// ===== testbench/dres_host.sv
// Serial host model that frames commands on its own clock.
`timescale 1ns/1ps
module dres_host (
	output logic o_sck,
	output logic o_cs_n,
	output logic o_mosi,
	input wire logic i_miso
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	task automatic xfer(input logic [7:0] opc, input logic [7:0] dat, input int nb,
		output logic [7:0] rd);
		logic [15:0] sh;
		sh = {opc, dat};
		rd = 8'h00;
		#3;
		o_cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			o_mosi = sh[15-i];
			#62.5;
			if (i >= 8) rd[15-i] = i_miso;
			o_sck = 1'b1;
			#62.5 o_sck = 1'b0;
		end
		#62.5 o_cs_n = 1'b1;
		// A released line flips so a stale bit cannot pass.
		o_mosi = ~o_mosi;
		#200;
	endtask : xfer
endmodule : dres_host

// ===== testbench/tb.sv
// Self-checking bench for the drive and error status register block.
`timescale 1ns/1ps
module tb;
	import dres_pkg::*;
	logic i_ref_clk, i_rst, i_sck, i_cs_n, i_mosi, o_miso, o_miso_oe_n, i_wp_n;
	logic i_status_write_disable_bit, i_write_busy_flag, i_soft_rst, i_op_end;
	logic i_op_fail, i_tgt_protected, i_tgt_suspended, i_ir_locked, i_asp_mode_set;
	logic i_pwd_match, i_block_protect_any, o_nv_write, nvw_seen, busy_e;
	dres_op_e i_op_kind;
	logic [1:0] i_asp_cur, i_asp_new, fl_e;
	logic [2:0] o_drive_strength, o_nv_drive_strength, ds_e, nv_e;
	logic [3:0] o_drive_eighths;
	logic [7:0] o_reg, rd;
	logic [3:0] e8t [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
	int err_count, checks;
	// A released line shows the inverse so a stale bit cannot pass.
	wire miso_w = o_miso_oe_n ? ~o_miso : o_miso;
	dres_top dut_u (.i_ref_clk, .i_rst, .i_sck, .i_cs_n, .i_mosi, .o_miso, .o_miso_oe_n,
		.i_wp_n, .i_status_write_disable_bit, .i_write_busy_flag, .i_soft_rst, .i_op_end,
		.i_op_kind, .i_op_fail, .i_tgt_protected, .i_tgt_suspended, .i_ir_locked,
		.i_asp_mode_set, .i_asp_cur, .i_asp_new, .i_pwd_match, .i_block_protect_any,
		.o_reg, .o_drive_strength, .o_nv_drive_strength, .o_drive_eighths, .o_nv_write);
	dres_host host_u (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_mosi(i_mosi), .i_miso(miso_w));
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) if (o_nv_write === 1'b1) nvw_seen <= 1'b1;
	task automatic cyc(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask : cyc
	function automatic logic [7:0] xreg();
		return {ds_e, 2'h2, fl_e, busy_e};
	endfunction : xreg
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic cmd(input logic [7:0] opc, input logic [7:0] dat, input int nb);
		host_u.xfer(opc, dat, nb, rd);
		cyc(8);
		chk(o_reg, xreg());
	endtask : cmd
	// Reads the register and lands back on a falling edge of the reference clock.
	task automatic rdreg;
		host_u.xfer(DRES_OPC_RD, 8'h00, 16, rd);
		cyc(1);
	endtask : rdreg
	task automatic op(input dres_op_e k, input logic [7:0] c, input logic [1:0] x);
		i_op_kind = k;
		{i_op_fail, i_tgt_protected, i_tgt_suspended, i_ir_locked, i_block_protect_any,
			i_pwd_match, i_asp_new} = c;
		i_op_end = 1'b1;
		cyc(1);
		i_op_end = 1'b0;
		{i_op_fail, i_tgt_protected, i_tgt_suspended, i_ir_locked, i_block_protect_any,
			i_pwd_match, i_asp_new} = 8'h07;
		fl_e = x;
		chk(o_reg, xreg());
		cyc(20);
		chk(o_reg, xreg());
		fl_e = 2'h0;
		cmd(DRES_OPC_CLR, 8'h00, 8);
	endtask : op
	task automatic t_codes;
		for (int c = 0; c < 8; c++) begin
			if (c[1:0] != 2'h0) ds_e = 3'(c);
			cmd(DRES_OPC_SET_V, {3'(c), 5'h1f}, 16);
			chk({5'h0, o_drive_strength}, {5'h0, ds_e});
			chk({4'h0, o_drive_eighths}, {4'h0, e8t[ds_e]});
			chk({5'h0, o_nv_drive_strength}, {5'h0, nv_e});
		end
		nvw_seen = 1'b0;
		ds_e = DRES_ODS_25;
		nv_e = DRES_ODS_25;
		cmd(DRES_OPC_SET_NV, 8'h5f, 16);
		chk({5'h0, o_nv_drive_strength}, {5'h0, nv_e});
		chk({7'h0, nvw_seen}, 8'h01);
		rdreg();
		chk(rd, xreg());
	endtask : t_codes
	task automatic t_busy;
		i_write_busy_flag = 1'b1;
		busy_e = 1'b1;
		rdreg();
		chk(rd, xreg());
		i_write_busy_flag = 1'b0;
		busy_e = 1'b0;
		cyc(2);
		chk(o_reg, xreg());
	endtask : t_busy
	task automatic t_lock;
		i_wp_n = 1'b0;
		i_status_write_disable_bit = 1'b1;
		cyc(4);
		op(DRES_OP_SR_WRITE, 8'h07, 2'h1);
		i_wp_n = 1'b1;
		cyc(4);
		op(DRES_OP_SR_WRITE, 8'h07, 2'h0);
		op(DRES_OP_SR_WRITE, 8'h87, 2'h2);
	endtask : t_lock
	task automatic t_soft;
		i_op_kind = DRES_OP_PWD_UNLOCK;
		i_pwd_match = 1'b0;
		i_op_end = 1'b1;
		cyc(1);
		i_op_end = 1'b0;
		i_pwd_match = 1'b1;
		fl_e = 2'h3;
		ds_e = DRES_ODS_100;
		cmd(DRES_OPC_SET_V, 8'hc0, 16);
		rdreg();
		chk(rd, xreg());
		i_soft_rst = 1'b1;
		cyc(1);
		i_soft_rst = 1'b0;
		fl_e = 2'h0;
		ds_e = nv_e;
		chk(o_reg, xreg());
	endtask : t_soft
	task automatic t_hwrst;
		i_op_kind = DRES_OP_PAGE_PGM;
		i_tgt_protected = 1'b1;
		i_op_end = 1'b1;
		cyc(1);
		i_op_end = 1'b0;
		i_tgt_protected = 1'b0;
		fl_e = 2'h3;
		chk(o_reg, xreg());
		i_rst = 1'b1;
		cyc(6);
		i_rst = 1'b0;
		cyc(2);
		chk(o_reg, 8'hf0);
		chk({5'h0, o_nv_drive_strength}, {5'h0, DRES_ODS_RST});
		fl_e = 2'h0;
		ds_e = DRES_ODS_RST;
		nv_e = DRES_ODS_RST;
		rdreg();
		chk(rd, xreg());
	endtask : t_hwrst
	initial begin
		#400us;
		err_count++;
		give_verdict();
	end
	initial begin
		{i_rst, i_wp_n, i_pwd_match, i_asp_mode_set, i_asp_cur, i_asp_new} = 8'hff;
		{i_status_write_disable_bit, i_write_busy_flag, i_soft_rst, i_op_end} = 4'h0;
		{i_op_fail, i_tgt_protected, i_tgt_suspended, i_ir_locked} = 4'h0;
		{i_block_protect_any, nvw_seen, busy_e, fl_e} = 5'h0;
		{ds_e, nv_e} = 6'h3f;
		i_op_kind = DRES_OP_OTHER;
		cyc(6);
		i_rst = 1'b0;
		cyc(2);
		chk(o_reg, 8'hf0);
		chk({4'h0, o_drive_eighths}, 8'h04);
		chk({7'h0, o_miso_oe_n}, 8'h01);
		t_codes();
		t_busy();
		op(DRES_OP_PAGE_PGM, 8'h87, 2'h2);
		op(DRES_OP_PAGE_PGM, 8'h47, 2'h3);
		op(DRES_OP_PPB_PGM, 8'h27, 2'h3);
		op(DRES_OP_PWD_PGM, 8'h27, 2'h3);
		op(DRES_OP_IR_PGM, 8'h17, 2'h3);
		op(DRES_OP_IR_PGM, 8'h87, 2'h2);
		op(DRES_OP_ASP_PGM, 8'h04, 2'h3);
		op(DRES_OP_ASP_PGM, 8'h06, 2'h3);
		i_asp_mode_set = 1'b0;
		op(DRES_OP_ASP_PGM, 8'h06, 2'h0);
		i_asp_mode_set = 1'b1;
		op(DRES_OP_PWD_UNLOCK, 8'h03, 2'h3);
		op(DRES_OP_NV_REG_WRITE, 8'h87, 2'h2);
		op(DRES_OP_FR_WRITE, 8'h87, 2'h2);
		op(DRES_OP_FR_WRITE, 8'h07, 2'h0);
		op(DRES_OP_SECT_ERASE, 8'h47, 2'h1);
		op(DRES_OP_IR_ERASE, 8'h17, 2'h1);
		op(DRES_OP_PPB_ERASE, 8'h47, 2'h1);
		op(DRES_OP_CHIP_ERASE, 8'h0f, 2'h1);
		op(DRES_OP_CHIP_ERASE, 8'h47, 2'h0);
		t_lock();
		t_soft();
		t_hwrst();
		give_verdict();
	end
endmodule : tb
bind dres_top dres_top_sva chk_u (.i_ref_clk, .i_rst, .i_write_busy_flag, .i_soft_rst,
	.i_op_end, .i_op_kind, .i_asp_new, .i_tgt_protected, .i_pwd_match,
	.i_block_protect_any, .o_reg, .o_drive_strength, .o_nv_drive_strength,
	.o_drive_eighths, .o_nv_write);
